// *** gp_consts.vh ***
// constants for the gpio pin control and pass-through block
// assumes a 32 pin port, one group register each for input and output
`ifndef GP_CONSTS_VH
`define GP_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define GP_ADDR_W        12
`define GP_OFF_CTL_BASE  12'h000
`define GP_OFF_IN_GRP    12'h300
`define GP_OFF_OUT_GRP   12'h380
`define GP_OFF_STATUS    12'h400
`define GP_OFF_MASK      12'h404

// ------------------------------------------------------------
// pin control field positions
// ------------------------------------------------------------
`define GP_F_DET         0
`define GP_F_PULL        3
`define GP_F_DIR         5
`define GP_F_OD          6
`define GP_F_OSEL        7
`define GP_F_ALT         8
`define GP_F_MUX         9
`define GP_F_PORT        11
`define GP_F_PWR         14
`define GP_F_INPUT       24
`define GP_CTL_W         16

// ------------------------------------------------------------
// encodings and reset values
// ------------------------------------------------------------
`define GP_DET_OFF       3'h0
`define GP_DET_HIGH      3'h1
`define GP_DET_LOW       3'h2
`define GP_DET_RISE      3'h3
`define GP_DET_FALL      3'h4
`define GP_DET_BOTH      3'h5
`define GP_PULL_UP       2'h1
`define GP_PULL_DN       2'h2
`define GP_MUX_GPIO      2'h0
`define GP_MUX_PT_IN     2'h1
`define GP_MUX_PT_OUT    2'h2
`define GP_PWR_UNPOWERED 2'h2
`define GP_PWR_IN_OFF    2'h3
`define GP_CTL_RST       16'h0000
`define GP_WORD_RST      32'h00000000

`endif

// *** gp_pads.sv ***
// pad model: resolves block drive, pulls and an outside driver per pin
// assumes the bench owns ext_val and ext_en
`timescale 1ns/1ns
module gp_pads (
	input  wire [31:0] pad_out,
	input  wire [31:0] pad_oe,
	input  wire [31:0] pull_up,
	input  wire [31:0] pull_dn,
	input  wire [31:0] ext_val,
	input  wire [31:0] ext_en,
	output wire [31:0] pad
);
	// a floating pin shows its pull if one is on, else the inverse of the last outside value, never a stale copy
	assign pad = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
		(~pad_oe & ~ext_en & (pull_up | (~pull_dn & ~ext_val)));
endmodule

// *** gp_pin_ctrl.v ***
// gpio pin block: synchronised inputs, push-pull or open-drain outputs,
// per-pin level/edge events with wake, eight pass-through ports.
// assumes pads resolve pad_out/pad_oe and pull controls outside.
//
// Operation
// (R1) inputs pass synchroniser before events and reads
// (R2) system reset clears all pin control state
// (R3) each pin has its own event output
// (R4) detection selects high, low, rise, fall, both
// (R5) pin event also forms a wake request
// (R6) outside pulses last at least 5ns
// (R7) edge wake caught asynchronously without clock
// (R8) output pins push-pull or open-drain selectable
// (R9) per-pin pull-up or pull-down control
// (R10) group or individual data, per-pin source select
// (R11) eight pass-through ports, own numbering zero-seven
// (R12) output pin mux field selects pass-through port
// (R13) firmware sets input and output pin muxes
// (R14) pass-through drives output from paired input
// (R15) input pin status keeps showing pad state
// (R16) events from consecutive synchronised samples
// (R17) input bit zero if disabled, one unpowered
// (R18) group input always shows pad states
`timescale 1ns/1ns
`include "gp_consts.vh"

module gp_pin_ctrl (
	input  wire        clk,
	input  wire        srst,
	input  wire [11:0] addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire [31:0] pad_in,
	output wire [31:0] pad_out,
	output wire [31:0] pad_oe,
	output wire [31:0] pull_up,
	output wire [31:0] pull_dn,
	output wire [31:0] pin_event,
	output wire [31:0] wake_req,
	output wire        irq
);

	// ------------------------------------------------------------
	// shared registers
	// ------------------------------------------------------------
	reg  [31:0]   out_grp;
	reg  [31:0]   status;
	reg  [31:0]   mask;
	wire [31:0]   cond_vec;
	wire [31:0]   sync_in;
	wire [1023:0] ctl_flat;
	wire [255:0]  pt_mat;
	wire [7:0]    pt_line;
	wire          ctl_region;
	wire          hit_out;
	wire          hit_mask;
	wire          hit_stat;
	reg  [31:0]   next_status;

	// ------------------------------------------------------------
	// register decode, full address compare except the pin control region, decoded on addr[11:7] and addr[6:2] only
	// ------------------------------------------------------------
	assign ctl_region = (addr[11:7] == 5'h00);
	assign hit_out    = (addr == `GP_OFF_OUT_GRP);
	assign hit_mask   = (addr == `GP_OFF_MASK);
	assign hit_stat   = (addr == `GP_OFF_STATUS);

	// ------------------------------------------------------------
	// pass-through port lines
	// ------------------------------------------------------------
	// raw pad level is routed, not the synchronised one, so the
	// port adds no clock latency; it is a wire path through the block
	genvar p;
	generate
		for (p = 0; p < 8; p = p + 1) begin : g_port
			assign pt_line[p] = |pt_mat[32*p +: 32]; // see (R11)
		end
	endgenerate

	// ------------------------------------------------------------
	// per-pin logic
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : g_pin
			localparam [4:0] PIN_IDX = i;
			reg  [15:0] ctl;
			reg         s1;
			reg         s2;
			reg         s3;
			reg         evt;
			reg         cond;
			reg         r_tog = 1'b0;
			reg         f_tog = 1'b0;
			reg         r_m = 1'b0;
			reg         r_s = 1'b0;
			reg         r_ack = 1'b0;
			reg         f_m = 1'b0;
			reg         f_s = 1'b0;
			reg         f_ack = 1'b0;
			wire [2:0]  det;
			wire [1:0]  pull;
			wire [1:0]  mux;
			wire [2:0]  port;
			wire [1:0]  pwr;
			wire        dir;
			wire        od;
			wire        is_pt_in;
			wire        is_pt_out;
			wire        pin_data;
			reg         in_stat;
			wire        wake_async;
			wire [7:0]  port_hot;
			wire        r_pend;
			wire        f_pend;
			wire        r_arm;
			wire        f_arm;
			reg         drv_val;
			reg         drv_en;
			reg         up_en;
			reg         dn_en;

			assign det  = ctl[`GP_F_DET +: 3];
			assign pull = ctl[`GP_F_PULL +: 2];
			assign mux  = ctl[`GP_F_MUX +: 2];
			assign port = ctl[`GP_F_PORT +: 3];
			assign pwr  = ctl[`GP_F_PWR +: 2];
			assign dir  = ctl[`GP_F_DIR];
			assign od   = ctl[`GP_F_OD];

			always @(posedge clk) begin
				if (srst) begin
					ctl <= `GP_CTL_RST; // see (R2)
				end else if (wr && ctl_region && addr[6:2] == PIN_IDX) begin
					ctl <= wdata[15:0];
				end
			end

			// two flops before use, a third keeps the previous sample
			always @(posedge clk) begin
				if (srst) begin
					s1  <= 1'b0;
					s2  <= 1'b0;
					s3  <= 1'b0;
					evt <= 1'b0;
				end else begin
					s1  <= pad_in[i]; // see (R1)
					s2  <= s1;
					s3  <= s2;
					evt <= cond; // see (R3)
				end
			end

			always @* begin
				case (det) // see (R4)
					`GP_DET_HIGH: cond = s2; // see (R16)
					`GP_DET_LOW:  cond = ~s2;
					`GP_DET_RISE: cond = s2 & ~s3;
					`GP_DET_FALL: cond = ~s2 & s3;
					`GP_DET_BOTH: cond = s2 ^ s3;
					default:      cond = 1'b0;
				endcase
			end

			// edge capture on the pad itself; no clock needed to flag it,
			// the clock only retires the request once it runs again
			always @(posedge pad_in[i]) begin
				r_tog <= ~r_tog; // see (R7)
			end

			always @(negedge pad_in[i]) begin
				f_tog <= ~f_tog; // see (R7)
			end

			always @(posedge clk) begin
				r_m   <= r_tog;
				r_s   <= r_m;
				r_ack <= r_s;
				f_m   <= f_tog;
				f_s   <= f_m;
				f_ack <= f_s;
			end

			// a pending edge lives from the pad toggle until the clocked
			// copy catches up; the arm terms keep it to the chosen edges
			assign r_pend     = r_tog ^ r_ack;
			assign f_pend     = f_tog ^ f_ack;
			assign r_arm      = (det == `GP_DET_RISE) || (det == `GP_DET_BOTH);
			assign f_arm      = (det == `GP_DET_FALL) || (det == `GP_DET_BOTH);
			assign wake_async = (r_arm & r_pend) | (f_arm & f_pend); // see (R7)

			assign pin_event[i] = evt;
			assign wake_req[i]  = evt | wake_async; // see (R5)
			assign cond_vec[i]  = cond;
			assign sync_in[i]   = s2;

			// pass-through roles; the far mux setup is firmware's job
			assign is_pt_in  = (mux == `GP_MUX_PT_IN) && !dir; // see (R13)
			assign is_pt_out = (mux == `GP_MUX_PT_OUT) && dir; // see (R12)
			assign port_hot  = 8'h01 << port;

			for (p = 0; p < 8; p = p + 1) begin : g_mat
				assign pt_mat[32*p + i] = is_pt_in && port_hot[p] && pad_in[i];
			end

			// normal data is cut off while the pin carries a port
			assign pin_data = is_pt_out ? pt_line[port] : // see (R14)
			                  (ctl[`GP_F_OSEL] ? ctl[`GP_F_ALT] : out_grp[i]); // see (R10)

			// open drain only ever pulls low; a one releases the pin
			always @* begin
				if (od) begin
					drv_val = 1'b0;
					drv_en  = dir & ~pin_data;
				end else begin
					drv_val = pin_data;
					drv_en  = dir;
				end
			end

			assign pad_out[i] = drv_val; // see (R8)
			assign pad_oe[i]  = drv_en;

			always @* begin
				up_en = 1'b0;
				dn_en = 1'b0;
				case (pull)
					`GP_PULL_UP: up_en = 1'b1; // see (R9)
					`GP_PULL_DN: dn_en = 1'b1;
					default:     up_en = 1'b0;
				endcase
			end

			assign pull_up[i] = up_en;
			assign pull_dn[i] = dn_en;

			// pass-through input pins report their pad like any other
			always @* begin
				case (pwr) // see (R17)
					`GP_PWR_IN_OFF:    in_stat = 1'b0;
					`GP_PWR_UNPOWERED: in_stat = 1'b1;
					default:           in_stat = s2; // see (R15)
				endcase
			end

			assign ctl_flat[32*i +: 32] = {7'h00, in_stat, 8'h00, ctl};
		end
	endgenerate

	// ------------------------------------------------------------
	// group output, event status and mask
	// ------------------------------------------------------------
	// a new event beats a write-one clear in the same cycle
	always @* begin
		next_status = status | cond_vec;
		if (wr && hit_stat) begin
			next_status = (status & ~wdata) | cond_vec;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			out_grp <= `GP_WORD_RST;
			mask    <= `GP_WORD_RST;
			status  <= `GP_WORD_RST;
		end else begin
			if (wr && hit_out) begin
				out_grp <= wdata; // see (R10)
			end
			if (wr && hit_mask) begin
				mask <= wdata;
			end
			status <= next_status; // see (R3)
		end
	end

	assign irq = |(status & mask);

	// ------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ------------------------------------------------------------
	// zero outside the answer cycle, so a late sample never sees stale data
	always @(posedge clk) begin
		if (srst) begin
			rdata <= `GP_WORD_RST;
		end else if (rd) begin
			if (ctl_region) begin
				rdata <= ctl_flat[32*addr[6:2] +: 32];
			end else begin
				case (addr)
					`GP_OFF_IN_GRP:  rdata <= sync_in; // see (R18)
					`GP_OFF_OUT_GRP: rdata <= out_grp;
					`GP_OFF_STATUS:  rdata <= status;
					`GP_OFF_MASK:    rdata <= mask;
					default:         rdata <= `GP_WORD_RST;
				endcase
			end
		end else begin
			rdata <= `GP_WORD_RST;
		end
	end

endmodule

// *** gp_pin_ctrl_note_end.v ***
`timescale 1ns/1ns

// *** gp_pin_ctrl_props.sv ***
// port checker for the pin block
// assumes one clock and srst synchronous active high
`timescale 1ns/1ns
`include "gp_consts.vh"
module gp_pin_ctrl_props (
	input wire        clk,
	input wire        srst,
	input wire [11:0] addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire [31:0] pad_in,
	input wire [31:0] pad_out,
	input wire [31:0] pad_oe,
	input wire [31:0] pull_up,
	input wire [31:0] pull_dn,
	input wire [31:0] pin_event,
	input wire [31:0] wake_req,
	input wire        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_rst; disable iff (1'b0) srst |=> pad_oe == 0 && pin_event == 0 && !irq && (pull_up | pull_dn) == 0;
	endproperty
	a_rst: assert property (p_rst) else $error("state not cleared by reset");
	property p_pull; (pull_up & pull_dn) == 0; endproperty
	a_pull: assert property (p_pull) else $error("pull up and down together");
	property p_wake; (pin_event & ~wake_req) == 0; endproperty
	a_wake: assert property (p_wake) else $error("event without wake");
	property p_ingrp; $stable(pad_in) [*4] ##0 (rd && addr == `GP_OFF_IN_GRP) |=> rdata == $past(pad_in); endproperty
	a_ingrp: assert property (p_ingrp) else $error("group input differs from pads");
	property p_mask; wr && addr == `GP_OFF_MASK && wdata == 0 |=> !irq; endproperty
	a_mask: assert property (p_mask) else $error("irq with all masked");
	// eight quiet cycles give the wake ack time to land
	property p_pend; $stable(pad_in) [*8] |-> (wake_req & ~pin_event) == 0; endproperty
	a_pend: assert property (p_pend) else $error("wake edge never acked");
	property p_ev; (!wr && $stable(pad_in)) [*5] |-> $stable(pin_event); endproperty
	a_ev: assert property (p_ev) else $error("event moved on quiet pads");
	property p_rdidle; !$past(rd) |-> rdata == 0; endproperty
	a_rdidle: assert property (p_rdidle) else $error("read data outside its cycle");
endmodule

// *** tb_top.sv ***
// bench for the pin block: events, pass-through, outputs, pad power
// assumes the pad model drives pad_in
`timescale 1ns/1ns
`include "gp_consts.vh"
module tb_top;
	reg         clk = 0;
	reg         srst = 1;
	reg  [11:0] addr = 0;
	reg  [31:0] wdata = 0;
	reg         wr = 0;
	reg         rd = 0;
	reg  [31:0] ext_val = 0;
	reg  [31:0] ext_en = 32'hfffffff7;
	reg  [31:0] got;
	wire [31:0] rdata, pad_in, pad_out, pad_oe, pull_up, pull_dn, pin_event, wake_req;
	wire        irq;
	integer     failures = 0;
	integer     num_checks = 0;
	integer     cyc = 0;
	integer     c;
	reg  [4:0]  e;
	// per detect code: status, event, status, event, status
	localparam [24:0] EV_TAB = {5'b00101, 5'b00100, 5'b00001, 5'b00111, 5'b11101};
	always #50 clk = ~clk;
	gp_pin_ctrl dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pull_up), .pull_dn(pull_dn),
		.pin_event(pin_event), .wake_req(wake_req), .irq(irq));
	gp_pads pads (.pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pull_up), .pull_dn(pull_dn),
		.ext_val(ext_val), .ext_en(ext_en), .pad(pad_in));
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks=%0d failures=%0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task w(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task wreg(input [11:0] a, input [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1;
			@(posedge clk);
			wr <= 0;
		end
	endtask
	task rreg(input [11:0] a);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1;
			@(posedge clk);
			rd <= 0;
			#1 got = rdata;
		end
	endtask
	task pin_set(input integer p, input v);
		begin
			@(posedge clk);
			ext_val[p] <= v;
			w(5);
		end
	endtask
	task ev_modes;
		begin
			wreg(`GP_OFF_MASK, 1);
			pin_set(0, 1);
			for (c = 1; c <= 5; c = c + 1) begin
				e = EV_TAB[5*(c-1) +: 5];
				wreg(`GP_OFF_CTL_BASE, c);
				w(4);
				wreg(`GP_OFF_STATUS, 1);
				rreg(`GP_OFF_STATUS);
				chk(got, e[4]);
				chk(pin_event[0], e[3]);
				pin_set(0, 0);
				rreg(`GP_OFF_STATUS);
				chk(got, e[2]);
				chk(pin_event[0], e[1]);
				wreg(`GP_OFF_STATUS, 1);
				w(4);
				pin_set(0, 1);
				rreg(`GP_OFF_STATUS);
				chk(got, e[0]);
				chk(irq, e[0]);
				wreg(`GP_OFF_CTL_BASE, 0);
				wreg(`GP_OFF_STATUS, 1);
			end
			wreg(`GP_OFF_MASK, 0);
		end
	endtask
	task o3(input [31:0] ctl, input [31:0] grp, input [3:0] exp);
		begin
			wreg(`GP_OFF_CTL_BASE + 12'hc, ctl);
			wreg(`GP_OFF_OUT_GRP, grp);
			w(1);
			chk({pull_dn[3], pull_up[3], pad_oe[3], pad_out[3]}, exp);
		end
	endtask
	task pass_out;
		begin
			wreg(`GP_OFF_CTL_BASE + 12'h4, 32'h1a00);
			wreg(`GP_OFF_CTL_BASE + 12'h8, 32'h1c20);
			for (c = 0; c < 2; c = c + 1) begin
				pin_set(1, c);
				chk({pad_oe[2], pad_out[2]}, {1'b1, c[0]});
				rreg(`GP_OFF_IN_GRP);
				chk(got[2:1], {2{c[0]}});
			end
			wreg(`GP_OFF_CTL_BASE + 12'h8, 32'h1c60);
			w(1);
			chk({pad_oe[2], pad_out[2]}, 2'b00);
			o3(32'h1a0, 0, 4'b0011);
			o3(32'h20, 8, 4'b0011);
			o3(32'h20, 0, 4'b0010);
			o3(32'h68, 8, 4'b0100);
			o3(32'h70, 8, 4'b1000);
		end
	endtask
	task pad_power;
		begin
			rreg(12'h800);
			chk(got, 0);
			pin_set(0, 0);
			wreg(`GP_OFF_CTL_BASE, 32'h8000);
			rreg(`GP_OFF_CTL_BASE);
			chk(got, 32'h01008000);
			rreg(`GP_OFF_IN_GRP);
			chk(got[0], 0);
			pin_set(0, 1);
			wreg(`GP_OFF_CTL_BASE, 32'hc000);
			rreg(`GP_OFF_CTL_BASE);
			chk(got, 32'hc000);
		end
	endtask
	task wake_edge;
		begin
			wreg(`GP_OFF_CTL_BASE, `GP_DET_RISE);
			pin_set(0, 0);
			wreg(`GP_OFF_STATUS, 1);
			@(posedge clk);
			ext_val[0] <= 1;
			#1;
			chk(wake_req[0], 1);
			chk(pin_event[0], 0);
			w(3);
			chk(pin_event[0], 1);
			chk(wake_req[0], 1);
			w(1);
			chk({wake_req[0], pin_event[0]}, 0);
			wreg(`GP_OFF_CTL_BASE, 0);
			wreg(`GP_OFF_STATUS, 1);
		end
	endtask
	task mid_reset;
		begin
			wreg(`GP_OFF_CTL_BASE, `GP_DET_HIGH);
			wreg(`GP_OFF_MASK, 1);
			wreg(`GP_OFF_CTL_BASE + 12'hc, 32'h1a8);
			w(4);
			chk({pull_up[3], pad_oe[3], irq}, 3'b111);
			@(posedge clk);
			srst <= 1;
			repeat (4) @(posedge clk);
			srst <= 0;
			w(1);
			chk(pad_oe, 0);
			chk({pull_up[3], irq, pin_event[0]}, 0);
			rreg(`GP_OFF_CTL_BASE + 12'hc);
			chk(got[15:0], 0);
		end
	endtask
	// ceiling well above the few hundred cycles the scenarios need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures = failures + 1;
			tally_and_finish;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		srst <= 0;
		w(1);
		chk(pad_oe, 0);
		chk(irq, 0);
		ev_modes;
		pass_out;
		pad_power;
		wake_edge;
		mid_reset;
		tally_and_finish;
	end
endmodule
bind gp_pin_ctrl gp_pin_ctrl_props props (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pull_up), .pull_dn(pull_dn),
	.pin_event(pin_event), .wake_req(wake_req), .irq(irq));
